//--- shared/lst_pkg.sv
// constants, field layout and timing for the line state and link error timers
// assumes one 100 MHz clock and a byte-wide control bus decoded by address
package lst_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int LS_W   = 3;
  // register addresses
  localparam logic [ADDR_W-1:0] A_NOISE_CNT  = 5'h0f;
  localparam logic [ADDR_W-1:0] A_NOISE_PRE  = 5'h10;
  localparam logic [ADDR_W-1:0] A_ST_START   = 5'h11;
  localparam logic [ADDR_W-1:0] A_SP_START   = 5'h12;
  localparam logic [ADDR_W-1:0] A_ST_CNT     = 5'h13;
  localparam logic [ADDR_W-1:0] A_SP_CNT     = 5'h14;
  localparam logic [ADDR_W-1:0] A_LE_START   = 5'h15;
  localparam logic [ADDR_W-1:0] A_LE_CNT     = 5'h16;
  localparam logic [ADDR_W-1:0] A_USER_IO    = 5'h17;
  // user_io_control field positions
  localparam int UIO_SB0 = 0;
  localparam int UIO_SB1 = 1;
  localparam int UIO_EB0 = 2;
  localparam int UIO_EB1 = 3;
  localparam int UIO_SB2 = 4;
  localparam int UIO_EB2 = 6;
  // reset values
  localparam logic [6:0] ST_START_RST = 7'h00;
  localparam logic [7:0] SP_START_RST = 8'h00;
  localparam logic [7:0] LE_START_RST = 8'h00;
  localparam logic [7:0] LE_CNT_RST   = 8'h00;
  localparam logic [2:0] ENABLE_RST   = 3'h0;
  // line state codes from the detector
  localparam logic [LS_W-1:0] LS_ACTIVE  = 3'h0;
  localparam logic [LS_W-1:0] LS_NOISE   = 3'h1;
  localparam logic [LS_W-1:0] LS_UNKNOWN = 3'h2;
  localparam logic [LS_W-1:0] LS_HALT    = 3'h3;
  localparam logic [LS_W-1:0] LS_IDLE    = 3'h4;
  localparam logic [LS_W-1:0] LS_MASTER  = 3'h5;
  localparam logic [LS_W-1:0] LS_QUIET   = 3'h6;
  localparam logic [LS_W-1:0] LS_NOSIG   = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYMBOL_NS     = 80;
  localparam int SYM_CYC       = SYMBOL_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = 3;
  localparam int SENSE_MIN_NS  = 80;
  localparam int SENSE_MIN_CYC =
    (SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SENSE_CNT_W   = 4;

  function automatic logic lst_timed(input logic [LS_W-1:0] ls);
    lst_timed = (ls == LS_HALT) || (ls == LS_IDLE) || (ls == LS_MASTER) ||
                (ls == LS_QUIET) || (ls == LS_NOSIG);
  endfunction
endpackage

//--- rtl/lst_sense_latch.sv
// sense pin synchronisers with minimum-width filter and sticky latch
// assumes sense pins are asynchronous and active high
`timescale 1ns/1ps
module lst_sense_latch
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // pins and host control
  input  wire logic [2:0] sense_pin,
  input  wire logic [2:0] clear,
  input  wire logic [2:0] bit_enable,
  // results
  output logic      [2:0] sense,
  output logic      [2:0] new_latch
);
  import lst_pkg::*;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_bit
      logic                   meta_reg, sync_reg, hit_reg, hit_next;
      logic                   new_reg, new_next;
      logic [SENSE_CNT_W-1:0] cnt_reg, cnt_next;

      always_comb
      begin
        cnt_next = '0;
        if (sync_reg && bit_enable[g])
        begin
          cnt_next = cnt_reg;
          if (cnt_reg != SENSE_CNT_W'(SENSE_MIN_CYC))
            cnt_next = cnt_reg + SENSE_CNT_W'(1);
        end
        new_next = bit_enable[g] && !hit_reg && !new_reg &&
                   (cnt_reg == SENSE_CNT_W'(SENSE_MIN_CYC - 1)) && sync_reg;
        // set beats clear so a pin held through the clear is kept
        hit_next = hit_reg;
        if (clear[g])
          hit_next = 1'b0;
        if (new_next || (cnt_reg == SENSE_CNT_W'(SENSE_MIN_CYC)))
          hit_next = bit_enable[g];
      end

      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          cnt_reg  <= '0;
          hit_reg  <= 1'b0;
          new_reg  <= 1'b0;
        end
        else
        begin
          meta_reg <= sense_pin[g];
          sync_reg <= meta_reg;
          cnt_reg  <= cnt_next;
          hit_reg  <= hit_next;
          new_reg  <= new_next;
        end
      end

      assign sense[g]     = hit_reg;
      assign new_latch[g] = new_reg;

      a_sense_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hit_reg && !clear[g] |=> hit_reg)
        else $error("sense bit dropped without a clear");
    end
  endgenerate
endmodule

//--- rtl/lst_timers.sv
// state timer, link error monitor, snapshots and user io register
// assumes bus strobes, line state and link errors share sys_clk
`timescale 1ns/1ps
module lst_timers
#(
  parameter bit DUAL_PATH = 1'b1
)
(
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // control bus
  input  wire logic                       cb_rd,
  input  wire logic                       cb_wr,
  input  wire logic [lst_pkg::ADDR_W-1:0] cb_addr,
  input  wire logic [lst_pkg::DATA_W-1:0] cb_wdata,
  output logic      [lst_pkg::DATA_W-1:0] cb_rdata,
  // line state detector and error strobe
  input  wire logic [lst_pkg::LS_W-1:0]   line_state,
  input  wire logic                       link_err,
  // noise timer values
  input  wire logic [6:0]                 noise_count,
  input  wire logic                       noise_change_detect,
  input  wire logic [7:0]                 noise_prescale,
  // events toward the interrupt condition register
  output logic                            write_reject_flag,
  output logic                            link_error_threshold_flag,
  output logic                            user_intr,
  // external user pins
  input  wire logic [2:0]                 sense_pin,
  output logic      [2:0]                 enable_pin
);
  import lst_pkg::*;

  // bus decode
  logic wr_st, wr_sp, wr_le, wr_uio, wr_ro;
  assign wr_st  = cb_wr && (cb_addr == A_ST_START);
  assign wr_sp  = cb_wr && (cb_addr == A_SP_START);
  assign wr_le  = cb_wr && (cb_addr == A_LE_START);
  assign wr_uio = cb_wr && (cb_addr == A_USER_IO);
  assign wr_ro  = cb_wr && ((cb_addr == A_NOISE_CNT) ||
                            (cb_addr == A_NOISE_PRE) ||
                            (cb_addr == A_ST_CNT) ||
                            (cb_addr == A_SP_CNT) ||
                            (cb_addr == A_LE_CNT));

  // symbol rate divider
  logic [DIV_W-1:0] div_reg, div_next;
  logic             tick;
  assign tick = (div_reg == DIV_W'(SYM_CYC - 1));

  always_comb
  begin
    div_next = tick ? '0 : div_reg + DIV_W'(1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      div_reg <= '0;
    else
      div_reg <= div_next;
  end

  // state timer
  logic [6:0]      str_reg, str_next, st_reg, st_next;
  logic [7:0]      state_prescale_start_reg, state_prescale_start_next, sp_reg, sp_next;
  logic [LS_W-1:0] ls_prev_reg;
  logic            sc_det_reg, sc_det_next;
  logic            timed, ls_change, entry, both_zero, load_both;

  assign timed     = lst_timed(line_state);
  assign ls_change = (line_state != ls_prev_reg);
  assign entry     = ls_change && timed;
  assign both_zero = (st_reg == 7'h00) && (sp_reg == 8'h00);
  assign load_both = wr_st || wr_sp || entry || (tick && timed && both_zero);

  always_comb
  begin
    str_next    = str_reg;
    state_prescale_start_next   = state_prescale_start_reg;
    st_next     = st_reg;
    sp_next     = sp_reg;
    sc_det_next = sc_det_reg;
    if (wr_st)
      str_next = cb_wdata[6:0];
    if (wr_sp)
      state_prescale_start_next = cb_wdata;
    if (load_both)
    begin
      st_next = str_next;
      sp_next = state_prescale_start_next;
    end
    else if (tick && timed)
    begin
      if (sp_reg == 8'h00)
      begin
        sp_next = state_prescale_start_reg;
        st_next = st_reg - 7'h01;
      end
      else
        sp_next = sp_reg - 8'h01;
    end
    // otherwise active, noise and unknown leave the timer frozen
    if (cb_rd && (cb_addr == A_ST_CNT))
      sc_det_next = 1'b0;
    // a change in the read cycle survives the clear
    if (ls_change)
      sc_det_next = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      str_reg     <= ST_START_RST;
      state_prescale_start_reg    <= SP_START_RST;
      st_reg      <= ST_START_RST;
      sp_reg      <= SP_START_RST;
      ls_prev_reg <= LS_ACTIVE;
      sc_det_reg  <= 1'b0;
    end
    else
    begin
      str_reg     <= str_next;
      state_prescale_start_reg    <= state_prescale_start_next;
      st_reg      <= st_next;
      sp_reg      <= sp_next;
      ls_prev_reg <= line_state;
      sc_det_reg  <= sc_det_next;
    end
  end

  // link error monitor
  logic [7:0] link_error_start_reg, link_error_start_next, lem_reg, lem_next;
  logic       lem_flag_reg, lem_flag_next;

  always_comb
  begin
    link_error_start_next     = link_error_start_reg;
    lem_next      = lem_reg;
    lem_flag_next = 1'b0;
    if (wr_le)
    begin
      link_error_start_next = cb_wdata;
      lem_next  = cb_wdata;
    end
    else if (link_err)
    begin
      // counting to zero and an idle zero both end in a reload
      if (lem_reg <= 8'h01)
      begin
        lem_next      = link_error_start_reg;
        lem_flag_next = 1'b1;
      end
      else
        lem_next = lem_reg - 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      link_error_start_reg     <= LE_START_RST;
      lem_reg      <= LE_CNT_RST;
      lem_flag_reg <= 1'b0;
    end
    else
    begin
      link_error_start_reg     <= link_error_start_next;
      lem_reg      <= lem_next;
      lem_flag_reg <= lem_flag_next;
    end
  end

  // user io register
  logic [2:0] eb_reg, eb_next, sense, new_latch, sense_clr, bit_en;
  logic       uintr_reg, uintr_next, rej_reg, rej_next;

  // the third pair is dead on single path parts
  assign bit_en    = {DUAL_PATH, 2'b11};
  assign sense_clr = {3{wr_uio}} & ~{cb_wdata[UIO_SB2], cb_wdata[UIO_SB1],
                                     cb_wdata[UIO_SB0]};

  lst_sense_latch u_sense
  (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .sense_pin  (sense_pin),
    .clear      (sense_clr),
    .bit_enable (bit_en),
    .sense      (sense),
    .new_latch  (new_latch)
  );

  always_comb
  begin
    eb_next = eb_reg;
    if (wr_uio)
      eb_next = {cb_wdata[UIO_EB2], cb_wdata[UIO_EB1], cb_wdata[UIO_EB0]};
    eb_next    = eb_next & bit_en;
    uintr_next = |new_latch;
    rej_next   = wr_ro;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      eb_reg    <= ENABLE_RST;
      uintr_reg <= 1'b0;
      rej_reg   <= 1'b0;
    end
    else
    begin
      eb_reg    <= eb_next;
      uintr_reg <= uintr_next;
      rej_reg   <= rej_next;
    end
  end

  assign enable_pin                = eb_reg;
  assign user_intr                 = uintr_reg;
  assign write_reject_flag         = rej_reg;
  assign link_error_threshold_flag = lem_flag_reg;

  // read data, captured from live values in the read cycle
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  always_comb
  begin
    rdata_next = rdata_reg;
    if (cb_rd)
    begin
      unique case (cb_addr)
        A_NOISE_CNT: rdata_next = {noise_change_detect, noise_count};
        A_NOISE_PRE: rdata_next = noise_prescale;
        A_ST_START:  rdata_next = {1'b0, str_reg};
        A_SP_START:  rdata_next = state_prescale_start_reg;
        A_ST_CNT:    rdata_next = {sc_det_reg, st_reg};
        A_SP_CNT:    rdata_next = sp_reg;
        A_LE_START:  rdata_next = link_error_start_reg;
        A_LE_CNT:    rdata_next = lem_reg;
        A_USER_IO:   rdata_next = {1'b0, eb_reg[2], 1'b0, sense[2],
                                   eb_reg[1], eb_reg[0], sense[1], sense[0]};
        default:     rdata_next = 8'h00;
      endcase
    end
  end
  // and place count low and change detect in bit 7 above

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign cb_rdata = rdata_reg;

  a_reject_on_ro: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_ro && !link_err |=> write_reject_flag && $stable(lem_reg))
    else $error("snapshot write not rejected");

  a_str_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cb_rd && (cb_addr == A_ST_START) |=> !cb_rdata[7])
    else $error("state threshold bit 7 not zero");

  a_write_loads_both: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_sp && !wr_st |=> (sp_reg == $past(cb_wdata)) && (st_reg == str_reg))
    else $error("threshold write did not load both");

  a_freeze_untimed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !timed && !wr_st && !wr_sp |=> $stable(st_reg) && $stable(sp_reg))
    else $error("state timer moved in untimed state");

  a_prescale_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tick && timed && !ls_change && !wr_st && !wr_sp && (sp_reg != 8'h00)
    |=> (sp_reg == $past(sp_reg) - 8'h01) && $stable(st_reg))
    else $error("prescaler did not step");

  a_entry_reload: assert property (@(posedge sys_clk) disable iff (!rst_b)
    entry && !wr_st && !wr_sp |=> (st_reg == str_reg) && (sp_reg == state_prescale_start_reg))
    else $error("entry did not reload timers");

  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tick |=> !tick [*7] ##1 tick)
    else $error("symbol tick spacing wrong");

  a_lem_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_le |=> (lem_reg == $past(cb_wdata)) && !link_error_threshold_flag)
    else $error("threshold write did not load counter");

  a_lem_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    link_err && !wr_le && (lem_reg == 8'h01)
    |=> link_error_threshold_flag && (lem_reg == link_error_start_reg))
    else $error("link error wrap missing");

  a_lem_reset: assert property (@(posedge sys_clk)
    !rst_b |=> (lem_reg == 8'h00) && !link_error_threshold_flag)
    else $error("link error counter not cleared by reset");

  a_enable_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_uio |=> enable_pin[0] == $past(cb_wdata[UIO_EB0]))
    else $error("enable pin not following write");
endmodule

//--- tb/lst_host_model.sv
// control bus host and line state detector facing the timer block
// assumes design inputs change at the falling edge of sys_clk
`timescale 1ns/1ps
module lst_host_model
(
  // clock
  input  wire logic                       sys_clk,
  // control bus
  output logic                            cb_rd,
  output logic                            cb_wr,
  output logic      [lst_pkg::ADDR_W-1:0] cb_addr,
  output logic      [lst_pkg::DATA_W-1:0] cb_wdata,
  input  wire logic [lst_pkg::DATA_W-1:0] cb_rdata,
  // detector side
  output logic      [lst_pkg::LS_W-1:0]   line_state,
  output logic                            link_err
);
  import lst_pkg::*;
  initial
  begin
    cb_rd      = 1'b0;
    cb_wr      = 1'b0;
    cb_addr    = 5'h00;
    cb_wdata   = 8'h00;
    line_state = LS_ACTIVE;
    link_err   = 1'b0;
  end
  // released bus shows the inverse so stale values never pass
  task automatic wr(input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    cb_wr    = 1'b1;
    cb_addr  = a;
    cb_wdata = d;
    @(negedge sys_clk);
    cb_wr    = 1'b0;
    cb_addr  = ~a;
    cb_wdata = ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    cb_rd   = 1'b1;
    cb_addr = a;
    @(negedge sys_clk);
    cb_rd   = 1'b0;
    cb_addr = ~a;
    d       = cb_rdata;
  endtask
  task automatic ls(input logic [LS_W-1:0] s);
    @(negedge sys_clk);
    line_state = s;
  endtask
  task automatic err();
    @(negedge sys_clk);
    link_err = 1'b1;
    @(negedge sys_clk);
    link_err = 1'b0;
  endtask
endmodule

//--- tb/lst_timers_tb.sv
// self-checking bench for the line state and link error timers
// assumes lst_pkg and the host model are compiled first
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("BAD %0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module lst_timers_tb;
  import lst_pkg::*;
  logic        sys_clk, rst_b, cb_rd, cb_wr, link_err;
  logic [4:0]  cb_addr;
  logic [7:0]  cb_wdata, cb_rdata, noise_prescale, d, exp_st, exp_sp;
  logic [2:0]  line_state, sense_pin, enable_pin, r_div, r_prev;
  logic [6:0]  noise_count, r_tim, r_st, n_st;
  logic        noise_change_detect, write_reject_flag, user_intr;
  logic        link_error_threshold_flag, r_cd, w_st, w_sp, chg;
  logic [7:0]  r_pre, r_sp, n_sp;
  logic [31:0] seed = 32'h660e;
  logic [31:0] k;
  int          err_count = 0;
  int          checks = 0;
  int          i, n;
  logic [4:0]  rw_list [5] = '{A_ST_START, A_SP_START, A_LE_START, A_LE_CNT,
                                A_USER_IO};
  logic [4:0]  ro_list [5] = '{A_NOISE_CNT, A_NOISE_PRE, A_ST_CNT, A_SP_CNT,
                                A_LE_CNT};

  lst_timers #(.DUAL_PATH(1'b1)) i_lst_timers (
    .sys_clk(sys_clk), .rst_b(rst_b), .cb_rd(cb_rd), .cb_wr(cb_wr),
    .cb_addr(cb_addr), .cb_wdata(cb_wdata), .cb_rdata(cb_rdata),
    .line_state(line_state), .link_err(link_err),
    .noise_count(noise_count), .noise_change_detect(noise_change_detect),
    .noise_prescale(noise_prescale), .write_reject_flag(write_reject_flag),
    .link_error_threshold_flag(link_error_threshold_flag),
    .user_intr(user_intr), .sense_pin(sense_pin), .enable_pin(enable_pin));
  lst_host_model i_lst_host_model (
    .sys_clk(sys_clk), .cb_rd(cb_rd), .cb_wr(cb_wr), .cb_addr(cb_addr),
    .cb_wdata(cb_wdata), .cb_rdata(cb_rdata), .line_state(line_state),
    .link_err(link_err));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // reference of the state timer; tick on every eighth edge out of reset
  assign w_st = cb_wr && (cb_addr == A_ST_START);
  assign w_sp = cb_wr && (cb_addr == A_SP_START);
  assign chg  = line_state != r_prev;
  assign n_st = w_st ? cb_wdata[6:0] : r_st;
  assign n_sp = w_sp ? cb_wdata : r_sp;
  always @(posedge sys_clk)
  begin
    r_prev <= line_state;
    if (!rst_b)
    begin
      r_div <= 3'h0;
      r_cd  <= 1'b0;
      r_tim <= 7'h00;
      r_pre <= 8'h00;
      r_st  <= 7'h00;
      r_sp  <= 8'h00;
    end
    else
    begin
      r_div <= r_div + 3'h1;
      r_st  <= n_st;
      r_sp  <= n_sp;
      if (cb_rd && cb_addr == A_ST_CNT)
      begin
        exp_st <= {r_cd, r_tim};
        r_cd   <= chg;
      end
      else if (chg)
        r_cd <= 1'b1;
      if (cb_rd && cb_addr == A_SP_CNT)
        exp_sp <= r_pre;
      if (w_st || w_sp || (chg && line_state >= LS_HALT))
      begin
        r_tim <= n_st;
        r_pre <= n_sp;
      end
      else if (r_div == 3'h7 && line_state >= LS_HALT)
      begin
        if (r_tim == 7'h00 && r_pre == 8'h00)
        begin
          r_tim <= r_st;
          r_pre <= r_sp;
        end
        else if (r_pre == 8'h00)
        begin
          r_pre <= r_sp;
          r_tim <= r_tim - 7'h01;
        end
        else
          r_pre <= r_pre - 8'h01;
      end
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #900000;
    err_count++;
    results();
  end

  initial
  begin
    rst_b = 1'b0;
    sense_pin = 3'h0;
    noise_count = 7'h00;
    noise_change_detect = 1'b0;
    noise_prescale = 8'h00;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    // reset values, link counter cleared
    for (i = 0; i < 5; i++)
    begin
      i_lst_host_model.rd(rw_list[i], d);
      `CHK(d, 8'h00)
    end
    `CHK(enable_pin, 3'h0)
    $display("test reset done");
    // read-only places refuse writes; unmapped place is silent
    for (i = 0; i < 5; i++)
    begin
      i_lst_host_model.wr(ro_list[i], 8'h5a);
      `CHK(write_reject_flag, 1'b1)
    end
    i_lst_host_model.wr(5'h1f, 8'hff);
    `CHK(write_reject_flag, 1'b0)
    i_lst_host_model.rd(5'h1f, d);
    `CHK(d, 8'h00)
    $display("test reject done");
    // noise snapshots follow the live values
    for (i = 0; i < 4; i++)
    begin
      k = xs();
      noise_count = k[6:0];
      noise_change_detect = k[7];
      noise_prescale = k[15:8];
      i_lst_host_model.rd(A_NOISE_CNT, d);
      `CHK(d, k[7:0])
      i_lst_host_model.rd(A_NOISE_PRE, d);
      `CHK(d, k[15:8])
    end
    $display("test noise done");
    // error on an empty counter wraps at once, then count down from n
    i_lst_host_model.err();
    `CHK(link_error_threshold_flag, 1'b1)
    n = 2 + xs() % 5;
    i_lst_host_model.wr(A_LE_START, 8'(n));
    i_lst_host_model.wr(A_LE_CNT, 8'hee);
    i_lst_host_model.rd(A_LE_CNT, d);
    `CHK(d, 8'(n))
    for (i = 1; i <= n; i++)
    begin
      i_lst_host_model.err();
      `CHK(link_error_threshold_flag, 1'(i == n))
      i_lst_host_model.rd(A_LE_CNT, d);
      `CHK(d, 8'(i == n ? n : n - i))
    end
    $display("test link error done");
    // state timer with small thresholds so it wraps often
    k = xs();
    // bit 7 written high must read back low
    i_lst_host_model.wr(A_ST_START, {1'b1, 4'h0, k[2:0]});
    i_lst_host_model.rd(A_ST_START, d);
    `CHK(d, {5'h00, k[2:0]})
    i_lst_host_model.wr(A_SP_START, 8'(k[9:8]));
    for (i = 0; i < 48; i++)
    begin
      k = xs();
      if (i < 8 || k[1:0] == 2'h0)
        i_lst_host_model.ls(i < 8 ? 3'(i) : k[6:4]);
      if (k[12:10] == 3'h0)
        i_lst_host_model.wr(k[13] ? A_ST_START : A_SP_START, 8'(k[15:14]));
      repeat (k[23:20] % 13) @(negedge sys_clk);
      i_lst_host_model.rd(A_ST_CNT, d);
      `CHK(d, exp_st)
      i_lst_host_model.rd(A_SP_CNT, d);
      `CHK(d, exp_sp)
    end
    $display("test state timer done");
    // enables, short sense blip ignored, long one latches and sticks
    d = 8'(xs()) & 8'h4c;
    k = {24'h0, d};
    i_lst_host_model.wr(A_USER_IO, k[7:0]);
    `CHK(enable_pin, {k[6], k[3], k[2]})
    sense_pin = 3'h1;
    repeat (3) @(negedge sys_clk);
    sense_pin = 3'h0;
    repeat (12) @(negedge sys_clk);
    i_lst_host_model.rd(A_USER_IO, d);
    `CHK(d, k[7:0])
    sense_pin = 3'h5;
    for (i = 0; i < 20 && user_intr !== 1'b1; i++)
      @(negedge sys_clk);
    `CHK(user_intr, 1'b1)
    if (i == 20)
      results();
    repeat (4) @(negedge sys_clk);
    sense_pin = 3'h0;
    repeat (6) @(negedge sys_clk);
    i_lst_host_model.rd(A_USER_IO, d);
    `CHK(d, k[7:0] | 8'h11)
    i_lst_host_model.wr(A_USER_IO, k[7:0]);
    i_lst_host_model.rd(A_USER_IO, d);
    `CHK(d, k[7:0])
    $display("test user io done");
    results();
  end
endmodule
